// *** include/sasp_defines.vh ***
// Notes on behaviour
// [R01]: Port has two data lines sharing one bit clock and one frame sync.
// [R02]: Each line is transmit or receive, with its own memory stream FIFO.
// [R03]: TDM frames carry up to 128 slots.
// [R04]: Bit rate never exceeds 50 Mbps, generated or external clock; the code limits only the generated clock.
// [R05]: Paired ports for TDM: one port both lines transmit, other both receive.
// [R06]: Five modes: standard, TDM, I2S, packed I2S, left-justified pair.
// [R07]: Left-justified pair: one sample on frame sync high, one on low.
// [R08]: I2S and left-justified pair carry four channels per port.
// [R09]: Bit order selectable, LSB first or MSB first.
// [R10]: Word length programmable from 3 to 32 bits.
// [R11]: I2S and left-justified pair limit word length to 8..32 bits.
// [R12]: Optional mu-law or A-law companding chosen per channel; the code selects it per line.
// [R13]: Bit clock and frame sync each internal or external.
// [R14]: Frame sync arriving during a word is flagged as an error.
// [R15]: Frame sync errors of all ports share one error interrupt.
// [R16]: Sticky frame sync error flag stays set until software clears it.
`ifndef SASP_DEFINES_VH
`define SASP_DEFINES_VH

// ****************************************
// Modes
// ****************************************
`define SASP_MODE_STD   3'h0
`define SASP_MODE_TDM   3'h1
`define SASP_MODE_I2S   3'h2
`define SASP_MODE_PI2S  3'h3
`define SASP_MODE_LJ    3'h4

// ****************************************
// Companding selects
// ****************************************
`define SASP_COMP_NONE  2'h0
`define SASP_COMP_MU    2'h1
`define SASP_COMP_A     2'h2
`define SASP_MU_BIAS    16'h0021
`define SASP_MU_CLIP    16'h1FFF
`define SASP_MU_DBIAS   16'h0084
`define SASP_A_DBIAS    16'h0108
`define SASP_A_XOR      8'h55

// ****************************************
// Word length limits (length minus one)
// ****************************************
`define SASP_WL_MIN     5'h02
`define SASP_WL_LVL_MIN 5'h07

// ****************************************
// Timing
// ****************************************
`define SASP_CLK_MHZ      200
`define SASP_MAX_MBPS     50
`define SASP_BIT_MIN_CYC  ((`SASP_CLK_MHZ + `SASP_MAX_MBPS - 1) / `SASP_MAX_MBPS)
`define SASP_HALF_MIN_CYC ((`SASP_BIT_MIN_CYC + 1) / 2)

`endif

// *** hw/sasp_serial_port.v ***
`include "sasp_defines.vh"
`default_nettype none

// ****************************************
// Word FIFO
// ****************************************
module sasp_fifo #(
  parameter W     = 32,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire         core_clk,  // Core clock
  input  wire         rst,       // Async reset
  input  wire         in_valid,  // Write request
  output wire         in_ready,  // Space available
  input  wire [W-1:0] in_data,   // Write word
  output wire         out_valid, // Word available
  input  wire         out_ready, // Read acknowledge
  output wire [W-1:0] out_data   // Head word
);
  reg [W-1:0]  mem_r [0:DEPTH-1];
  reg [AW-1:0] wr_r;
  reg [AW-1:0] rd_r;
  reg [AW:0]   cnt_r;
  wire         push;
  wire         pop;

  assign in_ready  = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data  = mem_r[rd_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_ready & out_valid;

  always @(posedge core_clk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_r  <= {AW{1'b0}};
      rd_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_r <= (wr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_r + 1'b1;
      end
      cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

// ****************************************
// Serial port
// ****************************************
module sasp_serial_port #(
  parameter W     = 32,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire           core_clk,      // 200 MHz core clock
  input  wire           rst,           // Async reset, active high
  input  wire           enable,        // Port enable
  input  wire [2:0]     mode,          // Operating mode
  input  wire [4:0]     word_len,      // Word length minus one
  input  wire           lsb_first,     // 1: LSB first
  input  wire           clk_internal,  // 1: generate bit clock
  input  wire           fs_internal,   // 1: generate frame sync
  input  wire [7:0]     clk_half,      // Bit clock half period, core cycles
  input  wire [6:0]     slots,         // Words per frame or half, minus one
  input  wire [1:0]     line_tx,       // Per line: 1 transmit, 0 receive
  input  wire [3:0]     comp_sel,      // Per line companding select
  input  wire           bclk_in,       // Bit clock pin input
  output wire           bclk_out,      // Bit clock pin output
  output wire           bclk_oe,       // Bit clock pin drive enable
  input  wire           fs_in,         // Frame sync pin input
  output wire           fs_out,        // Frame sync pin output
  output wire           fs_oe,         // Frame sync pin drive enable
  input  wire [1:0]     dl_in,         // Data line pin inputs
  output wire [1:0]     dl_out,        // Data line pin outputs
  output wire [1:0]     dl_oe,         // Data line drive enables
  input  wire [1:0]     mem_in_valid,  // Transmit words from memory valid
  output wire [1:0]     mem_in_ready,  // Transmit FIFO ready
  input  wire [2*W-1:0] mem_in_data,   // Transmit words, line 1 high
  output wire [1:0]     mem_out_valid, // Received word valid
  input  wire [1:0]     mem_out_ready, // Memory side accepts
  output wire [2*W-1:0] mem_out_data,  // Received words, line 1 high
  output wire           busy,          // Word in progress
  output wire           fs_err,        // Sticky frame sync error
  input  wire           fs_err_clr     // Clear the error flag
);
  localparam [7:0] HALF_MIN = `SASP_HALF_MIN_CYC;

  reg  [3:0]  sync1_r;
  reg  [3:0]  sync2_r;
  reg         bclk_int_r;
  reg  [7:0]  div_cnt_r;
  reg         fs_int_r;
  reg  [13:0] gen_cnt_r;
  reg         bclk_d_r;
  reg         fs_prev_r;
  reg         busy_r;
  reg  [4:0]  bit_cnt_r;
  reg  [6:0]  slot_r;
  reg         fs_err_r;

  wire        lvl_mode  = (mode == `SASP_MODE_I2S) | (mode == `SASP_MODE_PI2S) | // [R06]
                          (mode == `SASP_MODE_LJ);
  wire        first_lvl = (mode == `SASP_MODE_LJ);
  wire [7:0]  half_eff  = (clk_half < HALF_MIN) ? HALF_MIN : clk_half;   // [R04]
  wire [4:0]  wl_eff    = (lvl_mode && word_len < `SASP_WL_LVL_MIN) ? `SASP_WL_LVL_MIN : // [R11]
                          (word_len < `SASP_WL_MIN) ? `SASP_WL_MIN : word_len;           // [R10]
  wire [6:0]  nwords_m1 = ((mode == `SASP_MODE_TDM) | (mode == `SASP_MODE_PI2S)) ?
                          slots : 7'h00;                                     // [R03]
  wire [7:0]  nwords_p1 = {1'b0, nwords_m1} + 8'h01;
  wire [5:0]  wl_p1     = {1'b0, wl_eff} + 6'h01;
  wire [13:0] frame_bits = {6'h00, nwords_p1} * {8'h00, wl_p1};
  wire        gen_last  = (gen_cnt_r >= frame_bits - 14'h0001);
  wire        bclk_lvl  = clk_internal ? bclk_int_r : sync2_r[0];            // [R13]
  wire        fs_lvl    = fs_internal ? fs_int_r : sync2_r[1];               // [R13]
  wire        rise      = enable & bclk_lvl & ~bclk_d_r;
  wire        fall      = enable & ~bclk_lvl & bclk_d_r;
  // Pulse modes start on the rising frame sync, level modes on either edge
  wire        start     = rise & (lvl_mode ? (fs_lvl ^ fs_prev_r) : (fs_lvl & ~fs_prev_r)); // [R07]
  wire        done      = busy_r & (bit_cnt_r == wl_eff);
  wire        more      = (slot_r != nwords_m1);
  wire        load_tx   = start | (rise & done & more);
  wire [4:0]  idx       = lsb_first ? bit_cnt_r : wl_eff - bit_cnt_r;       // [R09]

  assign bclk_out = bclk_int_r;
  assign bclk_oe  = enable & clk_internal;
  assign fs_out   = fs_int_r;
  assign fs_oe    = enable & fs_internal;
  assign busy     = busy_r;
  assign fs_err   = fs_err_r;   // Ports OR these onto the shared error interrupt [R15]

  // ****************************************
  // Companding
  // ****************************************
  function [7:0] sasp_compress;
    input [15:0] lin;
    input        alaw;
    reg   [15:0] m;
    reg   [15:0] sh;
    reg   [3:0]  pos;
    reg   [3:0]  tmp;
    reg   [2:0]  seg;
    reg   [3:0]  mant;
    integer      k;
    begin
      m    = lin[15] ? (~lin + 16'h0001) : lin;
      pos  = 4'h0;
      seg  = 3'h0;
      mant = 4'h0;
      if (alaw) begin
        m = m >> 4;
        for (k = 5; k < 12; k = k + 1) begin
          if (m[k]) begin
            pos = k[3:0];
          end
        end
        if (pos == 4'h0) begin
          mant = m[4:1];
        end else begin
          tmp  = pos - 4'h4;
          seg  = tmp[2:0];
          sh   = m >> seg;
          mant = sh[3:0];
        end
        sasp_compress = {~lin[15], seg, mant} ^ `SASP_A_XOR;
      end else begin
        m = (m >> 2) + `SASP_MU_BIAS;
        if (m > `SASP_MU_CLIP) begin
          m = `SASP_MU_CLIP;
        end
        for (k = 5; k < 13; k = k + 1) begin
          if (m[k]) begin
            pos = k[3:0];
          end
        end
        tmp  = pos - 4'h5;
        seg  = tmp[2:0];
        sh   = m >> ({1'b0, seg} + 4'h1);
        mant = sh[3:0];
        sasp_compress = ~{lin[15], seg, mant};
      end
    end
  endfunction

  function [15:0] sasp_expand;
    input [7:0] code;
    input       alaw;
    reg   [7:0] c;
    reg   [15:0] t;
    begin
      if (alaw) begin
        c = code ^ `SASP_A_XOR;
        t = {8'h00, c[3:0], 4'h0};
        if (c[6:4] == 3'h0) begin
          t = t + 16'h0008;
        end else begin
          t = (t + `SASP_A_DBIAS) << (c[6:4] - 3'h1);
        end
        sasp_expand = c[7] ? t : (~t + 16'h0001);
      end else begin
        c = ~code;
        t = ({9'h000, c[3:0], 3'h0} + `SASP_MU_DBIAS) << c[6:4];
        sasp_expand = c[7] ? (`SASP_MU_DBIAS - t) : (t - `SASP_MU_DBIAS);
      end
    end
  endfunction

  // ****************************************
  // Pin synchronisers and clock generation
  // ****************************************
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1_r    <= 4'h0;
      sync2_r    <= 4'h0;
      bclk_int_r <= 1'b0;
      div_cnt_r  <= 8'h00;
      bclk_d_r   <= 1'b0;
    end else begin
      sync1_r  <= {dl_in, fs_in, bclk_in};
      sync2_r  <= sync1_r;
      bclk_d_r <= bclk_lvl;
      if (!enable || !clk_internal) begin
        bclk_int_r <= 1'b0;
        div_cnt_r  <= 8'h00;
      end else if (div_cnt_r >= half_eff - 8'h01) begin                  // [R04]
        bclk_int_r <= ~bclk_int_r;
        div_cnt_r  <= 8'h00;
      end else begin
        div_cnt_r <= div_cnt_r + 8'h01;
      end
    end
  end

  // Frame sync generator advances on bit clock falling edges
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gen_cnt_r <= 14'h3FFF;
      fs_int_r  <= 1'b0;
    end else if (!enable || !fs_internal) begin
      gen_cnt_r <= 14'h3FFF;
      fs_int_r  <= lvl_mode & ~first_lvl;
    end else if (fall) begin
      gen_cnt_r <= gen_last ? 14'h0000 : gen_cnt_r + 14'h0001;
      if (lvl_mode) begin
        fs_int_r <= fs_int_r ^ gen_last;                                   // [R07]
      end else begin
        fs_int_r <= gen_last;
      end
    end
  end

  // ****************************************
  // Word sequencer, shared by both lines
  // ****************************************
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fs_prev_r <= 1'b0;
      busy_r    <= 1'b0;
      bit_cnt_r <= 5'h00;
      slot_r    <= 7'h00;
      fs_err_r  <= 1'b0;
    end else begin
      // A new error in the clearing cycle still sets the flag
      fs_err_r <= (start & busy_r & ~done) | (fs_err_r & ~fs_err_clr);    // [R14] [R16]
      if (!enable) begin
        fs_prev_r <= lvl_mode & ~first_lvl;
        busy_r    <= 1'b0;
        bit_cnt_r <= 5'h00;
        slot_r    <= 7'h00;
      end else if (rise) begin
        fs_prev_r <= fs_lvl;
        if (start) begin
          busy_r    <= 1'b1;
          bit_cnt_r <= 5'h00;
          slot_r    <= 7'h00;
        end else if (done) begin
          busy_r    <= more;                                               // [R03]
          bit_cnt_r <= 5'h00;
          slot_r    <= more ? slot_r + 7'h01 : slot_r;
        end else if (busy_r) begin
          bit_cnt_r <= bit_cnt_r + 5'h01;
        end
      end
    end
  end

  // ****************************************
  // Per line data path
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_line                         // [R01]
      reg  [W-1:0] tx_sh_r;
      reg  [W-1:0] rx_sh_r;
      reg          dl_out_r;
      wire [1:0]   comp     = comp_sel[2*i+1:2*i];                       // [R12]
      wire         is_tx    = line_tx[i];                                // [R02] [R05]
      wire         f_in_rdy;
      wire         f_out_vld;
      wire [W-1:0] f_out_dat;
      wire [W-1:0] rx_nxt   = rx_sh_r | ({{(W-1){1'b0}}, sync2_r[2+i]} << idx);
      wire [15:0]  rx_lin   = sasp_expand(rx_nxt[7:0], comp == `SASP_COMP_A);
      wire [W-1:0] rx_word  = (comp == `SASP_COMP_NONE) ? rx_nxt :
                              {{(W-16){rx_lin[15]}}, rx_lin};
      wire [7:0]   tx_code  = sasp_compress(f_out_dat[15:0], comp == `SASP_COMP_A);
      wire         tx_pop   = load_tx & is_tx & f_out_vld;
      wire         rx_push  = rise & done & ~is_tx;

      assign dl_out[i]        = dl_out_r;
      assign dl_oe[i]         = enable & is_tx;
      assign mem_in_ready[i]  = is_tx & f_in_rdy;
      assign mem_out_valid[i] = ~is_tx & f_out_vld;
      assign mem_out_data[W*i +: W] = f_out_dat;

      sasp_fifo #(
        .W     (W),
        .DEPTH (DEPTH),
        .AW    (AW)
      ) u_fifo (
        .core_clk  (core_clk),
        .rst       (rst),
        .in_valid  (is_tx ? mem_in_valid[i] : rx_push),
        .in_ready  (f_in_rdy),
        .in_data   (is_tx ? mem_in_data[W*i +: W] : rx_word),
        .out_valid (f_out_vld),
        .out_ready (is_tx ? tx_pop : mem_out_ready[i]),
        .out_data  (f_out_dat)
      );

      always @(posedge core_clk or posedge rst) begin
        if (rst) begin
          tx_sh_r  <= {W{1'b0}};
          rx_sh_r  <= {W{1'b0}};
          dl_out_r <= 1'b0;
        end else begin
          // An empty FIFO at a word start sends zeros
          if (load_tx) begin
            if (!f_out_vld || !is_tx) begin
              tx_sh_r <= {W{1'b0}};
            end else if (comp == `SASP_COMP_NONE) begin
              tx_sh_r <= f_out_dat;
            end else begin
              tx_sh_r <= {{(W-8){1'b0}}, tx_code};                      // [R12]
            end
          end
          if (rise) begin
            if (start || done) begin
              rx_sh_r <= {W{1'b0}};
            end else if (busy_r) begin
              rx_sh_r <= rx_nxt;                                         // [R09]
            end
          end
          if (fall) begin
            dl_out_r <= busy_r & is_tx & tx_sh_r[idx];                   // [R08]
          end
        end
      end
    end
  endgenerate
endmodule

`default_nettype wire

// *** tb/sasp_port_props.sv ***
`default_nettype none
// ****************************************
// Port checker
// ****************************************
module sasp_port_props (
  input wire logic       core_clk,      // Clock
  input wire logic       rst,           // Reset
  input wire logic       enable,        // Enable
  input wire logic       clk_internal,  // Clock source
  input wire logic       fs_internal,   // Sync source
  input wire logic [1:0] line_tx,       // Directions
  input wire logic       bclk_out,      // Bit clock
  input wire logic       bclk_oe,       // Clock drive
  input wire logic       fs_oe,         // Sync drive
  input wire logic [1:0] dl_oe,         // Data drive
  input wire logic [1:0] mem_in_ready,  // Tx ready
  input wire logic [1:0] mem_out_valid, // Rx valid
  input wire logic       busy,          // Word active
  input wire logic       fs_err,        // Error flag
  input wire logic       fs_err_clr     // Error clear
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_bclk_drive_en: assert property (bclk_oe == (enable && clk_internal))
    else $error("bit clock drive mismatch");
  a_fs_drive_en: assert property (fs_oe == (enable && fs_internal))
    else $error("frame sync drive mismatch");
  a_data_drive_dir: assert property (dl_oe == (line_tx & {2{enable}}))
    else $error("data drive mismatch");
  a_rx_quiet_tx: assert property ((mem_out_valid & line_tx) == 2'h0)
    else $error("receive valid on transmit line");
  a_tx_quiet_rx: assert property ((mem_in_ready & ~line_tx) == 2'h0)
    else $error("transmit ready on receive line");
  a_bclk_rate_max: assert property (enable && $changed(bclk_out) |=> !enable || $stable(bclk_out))
    else $error("bit clock too fast");
  a_err_needs_busy: assert property ($rose(fs_err) |-> $past(busy))
    else $error("error without word in progress");
  a_err_stays_set: assert property (fs_err && !fs_err_clr |=> fs_err)
    else $error("error flag lost");
  a_err_clear_works: assert property (fs_err_clr && !enable |=> !fs_err)
    else $error("error flag not cleared");
  c_err: cover property ($rose(fs_err));
  c_rx: cover property (mem_out_valid[1] && !busy);
  c_gen: cover property ($rose(bclk_out) && busy);
endmodule
bind sasp_serial_port sasp_port_props u_props (.core_clk(core_clk), .rst(rst), .enable(enable),
  .clk_internal(clk_internal), .fs_internal(fs_internal), .line_tx(line_tx),
  .bclk_out(bclk_out), .bclk_oe(bclk_oe), .fs_oe(fs_oe), .dl_oe(dl_oe),
  .mem_in_ready(mem_in_ready), .mem_out_valid(mem_out_valid), .busy(busy),
  .fs_err(fs_err), .fs_err_clr(fs_err_clr));
`default_nettype wire

// *** tb/sasp_codec_model.sv ***
`default_nettype none
// ****************************************
// Far side codec
// ****************************************
module sasp_codec_model (
  input  wire logic        run,        // Codec makes clock
  input  wire logic        level,      // Sync change starts
  input  wire logic        idle,       // Sync level between frames
  input  wire logic        lsb_first,  // Bit order
  input  wire logic [4:0]  word_len,   // Bits minus one
  input  wire logic [6:0]  words,      // Words per start - 1
  input  wire logic [7:0]  frame_bits, // Sync spacing
  input  wire logic [31:0] tx_word,    // Word to port
  input  wire logic        bclk,       // Wire clock
  input  wire logic        fs,         // Wire sync
  input  wire logic        din,        // Data from port
  output var  logic        bclk_m,     // Codec clock
  output wire logic        fs_m,       // Codec sync
  output wire logic        dout,       // Data to port
  output var  logic [31:0] rx_word,    // Last word
  output var  int          rx_count    // Word count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] sh = '0;
  logic [7:0]  cnt = '0;
  logic [4:0]  k = '0;
  logic [6:0]  w = '0;
  logic        act = 1'b0;
  logic        fs_q = 1'b0;
  logic        d = 1'b0;
  logic        drv = 1'b0;
  logic        tog = 1'b0;
  logic        pls = 1'b0;
  initial begin
    bclk_m = 1'b0;
    rx_word = '0;
    rx_count = 0;
  end
  // Stands low while run is low; 80 ns keeps well under the top rate
  always begin
    #40;
    bclk_m = run & ~bclk_m;
  end
  always @(negedge bclk_m or negedge run) begin
    if (!run) begin
      cnt <= 8'h00;
      tog <= 1'b0;
      pls <= 1'b0;
    end else begin
      tog <= tog ^ (cnt == 8'h00);
      pls <= (cnt == 8'h00);
      cnt <= (cnt == frame_bits - 8'h01) ? 8'h00 : cnt + 8'h01;
    end
  end
  // Level modes rest at the port's idle level, so starting the clock makes no false half
  assign fs_m = level ? (tog ^ idle) : pls;
  always @(posedge run) fs_q = fs;
  // Capture first, so a sync on the last bit still closes the word
  always @(posedge bclk) begin
    if (act) begin
      sh[lsb_first ? k : word_len - k] = din;
      if (k == word_len) begin
        rx_word = sh;
        rx_count++;
        act = (w != words);
        w++;
        k = 5'h00;
        sh = '0;
      end
      else
        k++;
    end
    if (level ? fs !== fs_q : fs && !fs_q) begin
      act = 1'b1;
      k = 5'h00;
      w = 7'h00;
      sh = '0;
    end
    fs_q = fs;
  end
  // Release only on a falling edge, so the last bit still stands at its sampling edge
  always @(negedge bclk) begin
    d = tx_word[lsb_first ? k : word_len - k];
    drv = act;
  end
  // Released line shows the inverse, never a stale copy
  assign dout = drv ? d : ~d;
endmodule
`default_nettype wire

// *** tb/sasp_serial_port_bench.sv ***
`include "sasp_defines.vh"
`default_nettype none
module sasp_serial_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, rst, enable, lsb_first, clk_internal, fs_internal, fs_err_clr, m_idle;
  logic        bclk_out, bclk_oe, fs_out, fs_oe, busy, fs_err, bclk_m, fs_m, dout, m_run, m_lvl;
  logic [2:0]  mode;
  logic [4:0]  word_len, m_wl;
  logic [7:0]  clk_half, m_frame;
  logic [6:0]  slots, m_words;
  logic [1:0]  line_tx, dl_out, dl_oe, mem_in_valid, mem_in_ready, mem_out_valid, mem_out_ready;
  logic [3:0]  comp_sel;
  logic [63:0] mem_in_data, mem_out_data;
  logic [31:0] m_tx, rx_word, v, got, q[16];
  int          rx_count, bad_count, check_count, seed, n, base;
  wire         bclk_w = bclk_oe ? bclk_out : bclk_m;
  wire         fs_w = fs_oe ? fs_out : fs_m;
  wire [1:0]   dl_in = {dout, dl_out[0]};
  sasp_serial_port u_dut (.core_clk(core_clk), .rst(rst), .enable(enable), .mode(mode),
    .word_len(word_len), .lsb_first(lsb_first), .clk_internal(clk_internal),
    .fs_internal(fs_internal), .clk_half(clk_half), .slots(slots), .line_tx(line_tx),
    .comp_sel(comp_sel), .bclk_in(bclk_w), .bclk_out(bclk_out), .bclk_oe(bclk_oe),
    .fs_in(fs_w), .fs_out(fs_out), .fs_oe(fs_oe), .dl_in(dl_in), .dl_out(dl_out),
    .dl_oe(dl_oe), .mem_in_valid(mem_in_valid), .mem_in_ready(mem_in_ready),
    .mem_in_data(mem_in_data), .mem_out_valid(mem_out_valid), .mem_out_ready(mem_out_ready),
    .mem_out_data(mem_out_data), .busy(busy), .fs_err(fs_err), .fs_err_clr(fs_err_clr));
  sasp_codec_model u_codec (.run(m_run), .level(m_lvl), .lsb_first(lsb_first), .word_len(m_wl),
    .words(m_words), .frame_bits(m_frame), .tx_word(m_tx), .bclk(bclk_w), .fs(fs_w),
    .din(dl_out[0]), .bclk_m(bclk_m), .fs_m(fs_m), .dout(dout), .rx_word(rx_word),
    .rx_count(rx_count), .idle(m_idle));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  function automatic logic [31:0] mask(input logic [31:0] d, input logic [4:0] wl);
    return d & (32'hFFFFFFFF >> (5'h1F - wl));
  endfunction
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_cond(input int sel, input int lim);
    for (int i = 0; i < 5000; i++) begin
      @(posedge core_clk);
      #1;
      if (sel == 0 && rx_count >= lim || sel == 1 && mem_out_valid[1] === 1'b1 ||
          sel == 2 && fs_err === 1'b1)
        return;
    end
    check("wait", sel, 32'hFFFFFFFF);
    print_verdict();
  endtask
  task automatic cfg(input logic [2:0] md, input logic [4:0] wl, input logic ci,
                     input logic [3:0] cs);
    @(posedge core_clk);
    #1 enable = 1'b0;
    mode = md;
    word_len = wl;
    clk_internal = ci;
    fs_internal = ci;
    comp_sel = cs;
  endtask
  // Leaves valid high so back-to-back pushes never retoggle it in one step
  task automatic push(input logic [31:0] d);
    int i;
    i = 0;
    mem_in_data[31:0] = d;
    mem_in_valid = 2'h1;
    do @(posedge core_clk); while (mem_in_ready[0] !== 1'b1 && ++i < 50);
    check("push", 1, i < 50);
    if (i >= 50)
      print_verdict();
    else
      #1;
  endtask
  task automatic xfer(input logic [2:0] md, input logic [4:0] wl, input logic [3:0] cs,
                      input logic [4:0] mwl, input logic [31:0] tv, output logic [31:0] rv);
    cfg(md, wl, 1'b0, cs);
    m_wl = mwl;
    m_lvl = (md >= `SASP_MODE_I2S);
    m_idle = (md == `SASP_MODE_I2S) || (md == `SASP_MODE_PI2S);
    m_words = 7'h00;
    m_frame = {3'h0, mwl} + 8'h05;
    push(tv);
    mem_in_valid = 2'h0;
    enable = 1'b1;
    base = rx_count;
    m_run = 1'b1;
    wait_cond(0, base + 1);
    m_run = 1'b0;
    wait_cond(1, 0);
    rv = mem_out_data[63:32];
    mem_out_ready = 2'h2;
    @(posedge core_clk);
    #1 mem_out_ready = 2'h0;
  endtask
  initial begin
    seed = 32'h1F885E0F;
    {rst, enable, lsb_first, clk_internal, fs_internal, fs_err_clr, m_run, m_lvl} = 8'h80;
    {mode, word_len, clk_half, slots, m_wl, m_frame, m_words, m_idle} = '0;
    {comp_sel, mem_in_valid, mem_out_ready, mem_in_data, m_tx} = '0;
    line_tx = 2'h1;
    repeat (6) @(posedge core_clk);
    #1 rst = 1'b0;
    check("idle", 0, {busy, fs_err, mem_out_valid});
    for (n = 0; n < 6; n++) begin
      v = $random(seed);
      m_tx = $random(seed);
      lsb_first = n[1];
      m_wl = (n < 2) ? 5'h02 + 5'h1D * n[0] : 5'h02 + 5'({$random(seed)} % 30);
      xfer(`SASP_MODE_STD, m_wl, 4'h0, m_wl, v, got);
      check("port word", mask(m_tx, m_wl), got);
      check("line word", mask(v, m_wl), rx_word);
    end
    lsb_first = 1'b0;
    for (n = 0; n < 2; n++) begin
      m_tx = n ? 32'hD5 : 32'hFF;
      xfer(`SASP_MODE_STD, 5'h07, {2{n[1:0] + 2'h1}}, 5'h07, 32'h0, got);
      check("expanded", n ? 32'h8 : 32'h0, got);
      check("compressed", m_tx, rx_word);
    end
    for (n = 0; n < 3; n++) begin
      v = $random(seed);
      m_tx = $random(seed);
      xfer(`SASP_MODE_I2S + 3'(n), 5'h02, 4'h0, 5'h07, v, got);
      check("half rx", mask(m_tx, 5'h07), got);
      check("half tx", mask(v, 5'h07), rx_word);
    end
    cfg(`SASP_MODE_STD, 5'h0F, 1'b0, 4'h0);
    m_wl = 5'h0F;
    m_frame = 8'h08;
    m_lvl = 1'b0;
    enable = 1'b1;
    m_run = 1'b1;
    wait_cond(2, 0);
    m_run = 1'b0;
    repeat (40) @(posedge core_clk);
    check("error held", 1, fs_err);
    cfg(`SASP_MODE_TDM, 5'h07, 1'b1, 4'h0);
    fs_err_clr = 1'b1;
    @(posedge core_clk);
    #1 fs_err_clr = 1'b0;
    check("error cleared", 0, fs_err);
    line_tx = 2'h3;
    clk_half = 8'h04;
    slots = 7'h01;
    m_wl = 5'h07;
    m_words = 7'h01;
    for (n = 0; n < 16; n++) begin
      q[n] = $random(seed);
      push(q[n]);
    end
    mem_in_valid = 2'h0;
    check("fifo full", 0, mem_in_ready[0]);
    base = rx_count;
    enable = 1'b1;
    for (n = 0; n < 16; n++) begin
      wait_cond(0, base + n + 1);
      check("slot word", mask(q[n], 5'h07), rx_word);
    end
    check("fifo drained", 1, mem_in_ready[0]);
    print_verdict();
  end
endmodule
`default_nettype wire
